// *** pkg/ccs_pkg.sv ***
//
// Purpose: Shared constants and carriers for the charger control and status
//          register group.
// Assumes: A 250 MHz device clock and a byte-wide register port.
// Notes:   Every offset, field position, reset value and time lives here.
//
package ccs_pkg;

    // ************************************************************
    // Register offsets and port widths.
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_FIXED  = 4'h4;
    localparam logic [3:0] OFS_CTRL1  = 4'h5;
    localparam logic [3:0] OFS_CTRL2  = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;

    // ************************************************************
    // Reset and fixed values.
    // ************************************************************
    localparam logic [7:0] FIXED_VALUE = 8'h03;
    localparam logic [7:0] CTRL1_RESET = 8'h9d;
    localparam logic [7:0] CTRL2_RESET = 8'h33;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ************************************************************
    // Field positions of control register one.
    // ************************************************************
    localparam int C1_TERM      = 7;
    localparam int C1_KICK      = 6;
    localparam int C1_PERIOD_HI = 5;
    localparam int C1_PERIOD_LO = 4;
    localparam int C1_SAFE_EN   = 3;
    localparam int C1_DUR_HI    = 2;
    localparam int C1_DUR_LO    = 1;
    localparam int C1_SLOW      = 0;

    // ************************************************************
    // Field positions of control register two and the status register.
    // ************************************************************
    localparam int C2_THERM_HI  = 5;
    localparam int C2_THERM_LO  = 4;
    localparam int C2_CHG_EN    = 3;
    localparam int C2_LOWB_HI   = 1;
    localparam int C2_LOWB_LO   = 0;
    localparam logic [7:0] C2_WRITABLE = 8'h3b;
    localparam int ST_PG        = 7;
    localparam int ST_ICR       = 6;
    localparam int ST_IVR       = 5;
    localparam int ST_THERM     = 4;
    localparam int ST_EXPIRED   = 3;

    // ************************************************************
    // Decoded field values.
    // ************************************************************
    localparam logic [6:0]  THERM_BASE_C  = 7'd60;
    localparam logic [6:0]  THERM_STEP_C  = 7'd20;
    localparam logic [11:0] LOWB_BASE_MV  = 12'd2600;
    localparam logic [11:0] LOWB_STEP_MV  = 12'd300;
    localparam logic [2:0]  PHASE_IDLE    = 3'h0;
    localparam logic [2:0]  PHASE_CC      = 3'h3;
    localparam logic [2:0]  PHASE_CV      = 3'h4;

    // ************************************************************
    // Times and derived cycle counts.
    // ************************************************************
    localparam longint CLK_HZ            = 250_000_000;
    localparam longint TIMEOUT_BASE_S    = 40;
    localparam longint TIMEOUT_BASE_CYC  = TIMEOUT_BASE_S * CLK_HZ;
    localparam longint SAFETY_HOUR_S     = 3600;
    localparam longint SAFETY_HOUR_CYC   = SAFETY_HOUR_S * CLK_HZ;
    localparam logic [4:0] SAFETY_H0     = 5'd5;
    localparam logic [4:0] SAFETY_H1     = 5'd8;
    localparam logic [4:0] SAFETY_H2     = 5'd12;
    localparam logic [4:0] SAFETY_H3     = 5'd20;
    localparam int CNT_W                 = 48;

    // ************************************************************
    // Carriers.
    // ************************************************************
    typedef struct packed {
        logic       power_good_state;
        logic       input_current_reg_state;
        logic       input_voltage_reg_state;
        logic       thermal_reg_state;
        logic [2:0] charge_phase;
    } ccs_live_t;

    typedef struct packed {
        logic        termination_enable;
        logic        charge_enable;
        logic [6:0]  thermal_limit_c;
        logic [11:0] low_battery_mv;
        logic        safety_running;
        logic        safety_expired;
        logic        timeout_expired;
    } ccs_ctrl_t;

endpackage

// *** src/ccs_regs.sv ***
//
// Purpose: Control and status register group of the battery charger.
// Assumes: A serial front end turns bus transactions into byte-wide
//          register strobes on this port; live conditions arrive synchronous.
// Notes:   Host timeout and charge safety timer are kept here.
//
`timescale 1ns/1ps

// Functional notes
// - Register at offset 4 always reads 03h.
// - Changing the timeout period field restarts the timeout counter; same value does not.
// - Changing the safety duration field restarts the safety timer.
// - Bit 7 of control one enables charge termination.
// - Writing the kick bit restarts the timeout timer, then the bit self-clears.
// - Period codes 0..3 mean off, 40 s, 80 s, 160 s.
// - Safety timer runs only when enabled; codes give 5, 8, 12, 20 hours.
// - Slowdown bit halves safety timer rate during input or thermal regulation.
// - After timeout, charge enable held reset until a kick or period change, then re-enable.
// - Thermal field selects 60, 80, 100, 120 degrees Celsius.
// - Bit 3 of control two enables the charger.
// - Low-battery codes select 2.6, 2.9, 3.2, 3.5 volts.
// - Control two bits 7-6 and 2 always read zero.
// - Status bit 4 shows thermal regulation live.
// - Status bits 7, 6, 5 show power good and input regulations live.
// - Status bit 3 sets on timeout expiry; a kick or period change clears it.
// - Status bits 2-0 report charge phase: 0, 3 or 4.
// - Control one resets to 9Dh.
// - Control two resets to 33h.
module ccs_regs #(
    parameter longint TIMEOUT_CYC = ccs_pkg::TIMEOUT_BASE_CYC,
    parameter longint HOUR_CYC    = ccs_pkg::SAFETY_HOUR_CYC
) (
    // Clock and reset.
    input  wire logic                          CLK,
    input  wire logic                          SRST,
    // Register port.
    input  wire logic [ccs_pkg::ADDR_W-1:0]    REG_ADDR,
    input  wire logic                          REG_WR,
    input  wire logic [7:0]                    REG_WDATA,
    input  wire logic                          REG_RD,
    output logic [7:0]                         REG_RDATA,
    // Live charger conditions.
    input  wire ccs_pkg::ccs_live_t            LIVE,
    // Decoded control to the charger core.
    output ccs_pkg::ccs_ctrl_t                 CTRL
);

    localparam int CW = ccs_pkg::CNT_W;

    // ************************************************************
    // Elaboration check.
    // ************************************************************
    if (HOUR_CYC < 1 || (HOUR_CYC * 20) >= (64'd1 << CW)) begin : g_chk
        $error("ccs_regs: safety hour count does not fit the counter");
    end

    // ************************************************************
    // Declarations.
    // ************************************************************
    logic [7:0]    ctrl1;
    logic [7:0]    ctrl2;
    logic          expired;
    logic [7:0]    next_ctrl1;
    logic [7:0]    next_ctrl2;
    logic [7:0]    status_byte;
    logic [7:0]    read_mux;
    logic          wr_ctrl1;
    logic          wr_ctrl2;
    logic          kick;
    logic          period_change;
    logic          dur_change;
    logic          timeout_restart;
    logic          timeout_hit;
    logic [1:0]    period;
    logic [1:0]    dur;
    logic          safe_en;
    logic          slow_active;
    logic          safe_phase;
    logic          safe_step;
    logic [CW-1:0] safe_count;
    logic [CW-1:0] next_safe_count;
    logic [CW-1:0] safe_limit;
    logic [4:0]    safe_hours;
    logic          safe_done;
    logic [2:0]    phase_rpt;
    ccs_pkg::ccs_ctrl_t next_ctrl;

    // ************************************************************
    // Write decode.
    // ************************************************************

    // Status and fixed registers have no write strobe at all.
    assign wr_ctrl1 = REG_WR && (REG_ADDR == ccs_pkg::OFS_CTRL1);
    assign wr_ctrl2 = REG_WR && (REG_ADDR == ccs_pkg::OFS_CTRL2);

    // A kick is any control-one write with the kick bit set.
    assign kick = wr_ctrl1 && REG_WDATA[ccs_pkg::C1_KICK];

    // Only a different value counts as a change.
    assign period_change = wr_ctrl1 &&
        (REG_WDATA[ccs_pkg::C1_PERIOD_HI:ccs_pkg::C1_PERIOD_LO] !=
         ctrl1[ccs_pkg::C1_PERIOD_HI:ccs_pkg::C1_PERIOD_LO]);
    assign dur_change = wr_ctrl1 &&
        (REG_WDATA[ccs_pkg::C1_DUR_HI:ccs_pkg::C1_DUR_LO] !=
         ctrl1[ccs_pkg::C1_DUR_HI:ccs_pkg::C1_DUR_LO]);

    // Expiry rewrites the period to its default without a restart; the hit itself clears the count.
    assign timeout_restart = kick || period_change;

    // ************************************************************
    // Next register values.
    // ************************************************************

    // Expiry wins over a write in the same cycle: the host is presumed lost.
    always_comb begin
        next_ctrl1 = ctrl1;
        next_ctrl2 = ctrl2;
        next_ctrl1[ccs_pkg::C1_KICK] = 1'b0;
        if (timeout_hit) begin
            next_ctrl1 = ccs_pkg::CTRL1_RESET;
            next_ctrl2 = {ccs_pkg::CTRL2_RESET[7:2],
                          ctrl2[ccs_pkg::C2_LOWB_HI:ccs_pkg::C2_LOWB_LO]};
        end else begin
            if (wr_ctrl1) begin
                next_ctrl1 = REG_WDATA;
            end
            if (wr_ctrl2) begin
                next_ctrl2 = REG_WDATA & ccs_pkg::C2_WRITABLE;
            end
        end
        // Charging stays off while the timeout stands unserviced.
        if (expired && !kick) begin
            next_ctrl2[ccs_pkg::C2_CHG_EN] = 1'b0;
        end
    end

    // Register state with documented reset values.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl1 <= ccs_pkg::CTRL1_RESET;
            ctrl2 <= ccs_pkg::CTRL2_RESET;
        end else begin
            ctrl1 <= next_ctrl1;
            ctrl2 <= next_ctrl2;
        end
    end

    // Sticky expired flag: a new expiry beats a clearing kick.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            expired <= 1'b0;
        end else if (timeout_hit) begin
            expired <= 1'b1;
        end else if (timeout_restart) begin
            expired <= 1'b0;
        end
    end

    // ************************************************************
    // Host-timeout timer.
    // ************************************************************
    assign period = ctrl1[ccs_pkg::C1_PERIOD_HI:ccs_pkg::C1_PERIOD_LO];

    // The timer sees the old period on the change cycle and restarts anyway.
    ccs_timeout #(
        .BASE_CYC (TIMEOUT_CYC),
        .CNT_W    (CW)
    ) u_timeout (
        .clk     (CLK),
        .srst    (SRST),
        .period  (period),
        .restart (timeout_restart),
        .expire  (timeout_hit)
    );

    // ************************************************************
    // Charge safety timer.
    // ************************************************************
    assign dur     = ctrl1[ccs_pkg::C1_DUR_HI:ccs_pkg::C1_DUR_LO];
    assign safe_en = ctrl1[ccs_pkg::C1_SAFE_EN];

    // Duration code to hours.
    assign safe_hours = (dur == 2'd0) ? ccs_pkg::SAFETY_H0 :
                        (dur == 2'd1) ? ccs_pkg::SAFETY_H1 :
                        (dur == 2'd2) ? ccs_pkg::SAFETY_H2 :
                                        ccs_pkg::SAFETY_H3;
    assign safe_limit = CW'(HOUR_CYC) * CW'(safe_hours);

    // Half rate while slowed and any regulation loop is active.
    assign slow_active = ctrl1[ccs_pkg::C1_SLOW] &&
                         (LIVE.input_current_reg_state ||
                          LIVE.input_voltage_reg_state ||
                          LIVE.thermal_reg_state);
    assign safe_step = safe_en && !safe_done &&
                       (!slow_active || safe_phase);
    assign safe_done = (safe_count >= safe_limit);

    // A disabled timer or a new duration clears the count.
    assign next_safe_count = (!safe_en || dur_change) ? '0
                           : safe_step ? safe_count + CW'(1)
                           : safe_count;

    // The phase bit divides by two; it only matters in slowed mode.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            safe_count <= '0;
            safe_phase <= 1'b0;
        end else begin
            safe_count <= next_safe_count;
            safe_phase <= !safe_phase;
        end
    end

    // ************************************************************
    // Status and read path.
    // ************************************************************

    // Reserved phase codes are passed through unchanged from the core.
    assign phase_rpt = LIVE.charge_phase;

    assign status_byte = {LIVE.power_good_state,
                          LIVE.input_current_reg_state,
                          LIVE.input_voltage_reg_state,
                          LIVE.thermal_reg_state,
                          expired,
                          phase_rpt};

    assign read_mux =
        (REG_ADDR == ccs_pkg::OFS_FIXED)  ? ccs_pkg::FIXED_VALUE :
        (REG_ADDR == ccs_pkg::OFS_CTRL1)  ? ctrl1 :
        (REG_ADDR == ccs_pkg::OFS_CTRL2)  ? ctrl2 :
        (REG_ADDR == ccs_pkg::OFS_STATUS) ? status_byte :
                                            ccs_pkg::UNMAPPED_READ;

    // Read data is captured on the read strobe and held until the next.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= read_mux;
        end
    end

    // ************************************************************
    // Decoded control outputs.
    // ************************************************************
    always_comb begin
        next_ctrl = '0;
        next_ctrl.termination_enable = ctrl1[ccs_pkg::C1_TERM];
        next_ctrl.charge_enable      = ctrl2[ccs_pkg::C2_CHG_EN];
        next_ctrl.thermal_limit_c    = ccs_pkg::THERM_BASE_C +
            7'(ctrl2[ccs_pkg::C2_THERM_HI:ccs_pkg::C2_THERM_LO] *
               ccs_pkg::THERM_STEP_C);
        next_ctrl.low_battery_mv     = ccs_pkg::LOWB_BASE_MV +
            12'(ctrl2[ccs_pkg::C2_LOWB_HI:ccs_pkg::C2_LOWB_LO] *
                ccs_pkg::LOWB_STEP_MV);
        next_ctrl.safety_running     = safe_en && !safe_done;
        next_ctrl.safety_expired     = safe_en && safe_done;
        next_ctrl.timeout_expired    = expired;
    end

    // Registered so the core sees glitch-free settings.
    always_ff @(posedge CLK) begin
        if (SRST) begin
            CTRL <= '0;
        end else begin
            CTRL <= next_ctrl;
        end
    end

endmodule // ccs_regs

// *** src/ccs_timeout.sv ***
//
// Purpose: Host-timeout timer with a two-bit period code.
// Assumes: Restart is a one-cycle pulse from the register logic.
// Notes:   Code 0 stops the timer; 1, 2, 3 give 1x, 2x, 4x the base.
//
`timescale 1ns/1ps
module ccs_timeout #(
    parameter longint BASE_CYC = ccs_pkg::TIMEOUT_BASE_CYC,
    parameter int     CNT_W    = ccs_pkg::CNT_W
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       srst,
    // Control.
    input  wire logic [1:0] period,
    input  wire logic       restart,
    // Result.
    output logic            expire
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] limit;
    logic             running;
    logic             hit;

    // ************************************************************
    // Elaboration check.
    // ************************************************************
    if (BASE_CYC < 1 || (BASE_CYC * 4) >= (64'd1 << CNT_W)) begin : g_chk
        $error("ccs_timeout: base count does not fit the counter");
    end

    // Period decode: 1x, 2x, 4x of the base, zero disables.
    assign running = (period != 2'd0);
    assign limit   = CNT_W'(BASE_CYC) << (period - 2'd1);
    assign hit     = running && (count == limit - CNT_W'(1));
    assign next_count = (restart || !running || hit) ? '0
                      : count + CNT_W'(1);

    // The expiry pulse is registered so the register logic sees it clean.
    always_ff @(posedge clk) begin
        if (srst) begin
            count  <= '0;
            expire <= 1'b0;
        end else begin
            count  <= next_count;
            expire <= hit && !restart;
        end
    end

endmodule // ccs_timeout

// *** verification/ccs_checker.sv ***
// Purpose: Assertions on the register port and decoded control outputs.
// Assumes: Sees only the ports of ccs_regs; one clock domain.
// Notes:   Control checks skip writes that could race a timeout expiry.
`timescale 1ns/1ps
module ccs_checker #(
    parameter longint TIMEOUT_CYC = 20,
    parameter longint HOUR_CYC    = 10
) (
    // Clock and reset.
    input wire logic                       CLK,
    input wire logic                       SRST,
    // Register port.
    input wire logic [ccs_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic                       REG_WR,
    input wire logic [7:0]                 REG_WDATA,
    input wire logic                       REG_RD,
    input wire logic [7:0]                 REG_RDATA,
    // Live conditions and decoded control.
    input wire ccs_pkg::ccs_live_t         LIVE,
    input wire ccs_pkg::ccs_ctrl_t         CTRL
);
    // ************************************************************
    // Request decode.
    // ************************************************************
    // A write that also parks the timeout cannot be followed by an expiry; one in its own cycle still wins.
    wire wr5 = REG_WR && REG_ADDR == ccs_pkg::OFS_CTRL1;
    wire wr_c1 = wr5 && REG_WDATA[5:4] == 2'b00;
    wire wr_c2 = REG_WR && REG_ADDR == ccs_pkg::OFS_CTRL2
                 && !CTRL.timeout_expired;
    wire rd4 = REG_RD && REG_ADDR == ccs_pkg::OFS_FIXED;
    wire rd5 = REG_RD && REG_ADDR == ccs_pkg::OFS_CTRL1;
    wire rd6 = REG_RD && REG_ADDR == ccs_pkg::OFS_CTRL2;
    wire rd7 = REG_RD && REG_ADDR == ccs_pkg::OFS_STATUS;

    // ************************************************************
    // Properties.
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    AST_FIXED_READ: assert property (
        rd4 |=> REG_RDATA == 8'h03) else $error("Fixed read wrong.");
    AST_CTRL2_ZEROS: assert property (
        rd6 |=> (REG_RDATA & 8'hc4) == 8'h00) else $error("Reserved set.");
    AST_STATUS_LIVE: assert property (
        rd7 |=> {REG_RDATA[7:4], REG_RDATA[2:0]} == $past(LIVE))
        else $error("Status does not follow live inputs.");
    AST_RESET_DEFAULTS: assert property (
        $fell(SRST) |=> CTRL.termination_enable && !CTRL.charge_enable
        && CTRL.thermal_limit_c == 7'd120 && CTRL.safety_running
        && CTRL.low_battery_mv == 12'd3500 && !CTRL.timeout_expired)
        else $error("Control defaults wrong after reset.");
    AST_TERM_EN: assert property (
        wr_c1 |=> ##1 CTRL.termination_enable == $past(REG_WDATA[7], 2))
        else $error("Termination enable wrong.");
    AST_SAFETY_OFF: assert property (
        wr_c1 && !REG_WDATA[3] |=> ##1 !CTRL.safety_running)
        else $error("Safety timer runs while disabled.");
    AST_CHG_EN: assert property (
        wr_c2 |=> ##1 CTRL.charge_enable == $past(REG_WDATA[3], 2))
        else $error("Charge enable wrong.");
    AST_THERM: assert property (
        wr_c2 |=> ##1 CTRL.thermal_limit_c
        == 7'd60 + 7'd20 * $past(REG_WDATA[5:4], 2))
        else $error("Thermal limit wrong.");
    AST_LOWB: assert property (
        wr_c2 |=> ##1 CTRL.low_battery_mv
        == 12'd2600 + 12'd300 * $past(REG_WDATA[1:0], 2))
        else $error("Low battery threshold wrong.");
    AST_KICK_CLEAR: assert property (
        rd5 && !$past(wr5) |=> !REG_RDATA[6]) else $error("Kick stuck.");
    AST_EXPIRED_NO_CHG: assert property (
        CTRL.timeout_expired |-> !CTRL.charge_enable)
        else $error("Charger enabled after timeout.");

    // Main scenarios reached.
    COV_EXPIRED: cover property (rd7 ##1 REG_RDATA[3]);
    COV_SAFETY: cover property ($rose(CTRL.safety_expired));
    COV_CHG: cover property (wr_c2 && REG_WDATA[3]);
endmodule // ccs_checker

bind ccs_regs ccs_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .HOUR_CYC(HOUR_CYC))
    u_chk (.CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
           .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
           .LIVE(LIVE), .CTRL(CTRL));

// *** verification/ccs_host_model.sv ***
// Purpose: Host side model issuing byte strobes to the register group.
// Assumes: Strobes are launched just after a rising edge.
// Notes:   Write data is inverted once released so stale values never pass.
`timescale 1ns/1ps
module ccs_host_model (
    // Clock.
    input  wire logic                       clk,
    // Register strobes toward the device.
    output logic [ccs_pkg::ADDR_W-1:0]      reg_addr,
    output logic                            reg_wr,
    output logic [7:0]                      reg_wdata,
    output logic                            reg_rd,
    // Read data from the device.
    input  wire logic [7:0]                 reg_rdata
);
    // Idle strobes from time zero.
    initial begin
        reg_addr = '0;
        reg_wr = 1'b0;
        reg_wdata = '0;
        reg_rd = 1'b0;
    end

    // One write strobe held for exactly one sampling edge.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // Read data is taken one edge after the strobe was sampled.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule // ccs_host_model

// *** verification/ccs_regs_tb_top.sv ***
// Purpose: Self-checking bench for the charger register group.
// Assumes: Short timer parameters so that expiries come within a few hundred cycles.
// Notes:   Timer figures are checked against windows, not exact cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    fail_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module ccs_regs_tb_top;
    // ************************************************************
    // Signals and instances.
    // ************************************************************
    logic                       clk = 1'b0;
    logic                       srst = 1'b1;
    logic [ccs_pkg::ADDR_W-1:0] addr;
    logic                       wr;
    logic                       rd;
    logic [7:0]                 wdata;
    logic [7:0]                 rdata;
    logic [7:0]                 d;
    ccs_pkg::ccs_live_t         live = '0;
    ccs_pkg::ccs_ctrl_t         ctrl;
    int                         fail_count = 0;
    int                         check_count = 0;
    int                         cyc = 0;
    int                         n;

    ccs_host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));
    ccs_regs #(.TIMEOUT_CYC(20), .HOUR_CYC(10)) dut (.CLK(clk),
        .SRST(srst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
        .REG_RD(rd), .REG_RDATA(rdata), .LIVE(live), .CTRL(ctrl));

    // Clock of 4 ns and a cycle ceiling that cuts a hang short.
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ************************************************************
    // Shared tasks.
    // ************************************************************
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Counts edges until an expiry flag shows, bounded by lim.
    task automatic wait_set(input bit safe, input int lim, output int k);
        k = 0;
        while ((safe ? ctrl.safety_expired : ctrl.timeout_expired) !== 1'b1
               && k < lim) begin
            @(posedge clk);
            k++;
        end
    endtask

    // Reset, read defaults, then park the timeout before it can fire.
    task automatic t_reset();
        srst <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        host.rd(4'h5, d);
        `CHK("ctrl1 reset", 8'h9d, d);
        host.rd(4'h6, d);
        `CHK("ctrl2 reset", 8'h33, d);
        host.wr(4'h4, 8'hff);
        host.rd(4'h4, d);
        `CHK("fixed value", 8'h03, d);
        host.rd(4'hf, d);
        `CHK("unmapped read", 8'h00, d);
        host.wr(4'h5, 8'h00);
        $display("test reset done");
    endtask

    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic t_regs();
        logic [6:0] k;
        for (int i = 0; i < 4; i++) begin
            k = i[6:0];
            host.wr(4'h6, {2'b11, k[1:0], 2'b11, k[1:0]});
            host.rd(4'h6, d);
            `CHK("ctrl2", {2'b00, k[1:0], 2'b10, k[1:0]}, d);
            `CHK("thermal", 60 + 20 * k, ctrl.thermal_limit_c);
            `CHK("lowb", 2600 + 300 * k, ctrl.low_battery_mv);
            `CHK("charge on", 1'b1, ctrl.charge_enable);
        end
        host.wr(4'h6, 8'h00);
        host.wr(4'h5, 8'h80);
        repeat (2) @(posedge clk);
        `CHK("term on", 1'b1, ctrl.termination_enable);
        host.wr(4'h5, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("term off", 1'b0, ctrl.termination_enable);
        `CHK("charge off", 1'b0, ctrl.charge_enable);
        $display("test regs done");
    endtask

    // Writes to the status register must not disturb the live view.
    task automatic t_status();
        logic [2:0] ph [3] = '{3'h0, 3'h3, 3'h4};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            live <= {i[0], ~i[0], i[1], ~i[1], ph[i]};
            host.wr(4'h7, 8'h08);
            host.rd(4'h7, d);
            `CHK("status", {live[6:3], 1'b0, live[2:0]}, d);
        end
        $display("test status done");
    endtask

    task automatic t_safety();
        host.wr(4'h5, 8'h0c);
        repeat (30) @(posedge clk);
        host.wr(4'h5, 8'h08);
        wait_set(1'b1, 120, n);
        `CHK("safety span", 1'b1, n >= 49 && n <= 56);
        host.wr(4'h5, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("safety off", 1'b0, ctrl.safety_running);
        live <= 7'h08;
        host.wr(4'h5, 8'h09);
        wait_set(1'b1, 200, n);
        `CHK("slow span", 1'b1, n >= 98 && n <= 108);
        host.wr(4'h5, 8'h00);
        live <= '0;
        $display("test safety done");
    endtask

    // Kick restarts, expiry reloads defaults except the low-battery field, kick then enable resumes charging.
    task automatic t_timeout();
        host.wr(4'h6, 8'h39);
        host.wr(4'h5, 8'h50);
        repeat (12) @(posedge clk);
        host.wr(4'h5, 8'h50);
        wait_set(1'b0, 60, n);
        `CHK("kick span", 1'b1, n >= 19 && n <= 26);
        host.rd(4'h7, d);
        `CHK("expired bit", 1'b1, d[3]);
        host.rd(4'h6, d);
        `CHK("ctrl2 expired", 8'h31, d);
        host.rd(4'h5, d);
        `CHK("ctrl1 expired", 8'h9d, d);
        host.wr(4'h6, 8'h39);
        host.wr(4'h5, 8'h40);
        host.rd(4'h6, d);
        `CHK("enable held", 8'h31, d);
        host.wr(4'h6, 8'h39);
        host.rd(4'h6, d);
        `CHK("enable resumed", 8'h39, d);
        host.rd(4'h7, d);
        `CHK("expired cleared", 1'b0, d[3]);
        host.wr(4'h5, 8'h10);
        repeat (10) @(posedge clk);
        host.wr(4'h5, 8'h10);
        wait_set(1'b0, 60, n);
        `CHK("same value span", 1'b1, n >= 8 && n <= 16);
        host.wr(4'h5, 8'h40);
        host.wr(4'h5, 8'h20);
        wait_set(1'b0, 80, n);
        `CHK("80 s span", 1'b1, n >= 39 && n <= 46);
        host.wr(4'h5, 8'h00);
        host.wr(4'h5, 8'h30);
        wait_set(1'b0, 99, n);
        `CHK("160 s span", 1'b1, n >= 79 && n <= 86);
        $display("test timeout done");
    endtask

    // Main sequence, ending with a reset in mid-run.
    initial begin
        t_reset();
        t_regs();
        t_status();
        t_safety();
        t_timeout();
        t_reset();
        wrap_up();
    end
endmodule // ccs_regs_tb_top
